// >>> design/auto_reload_timer_split.sv
// Split-capable auto-reload timer with AXI4-Lite register slave and interrupt
//
// Chosen here: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps
`include "timer_regs.svh"

// Notes on behaviour
// - Timer is two eight-bit count bytes, low and high, both software readable and writable.
// - Split select clear runs both bytes as one sixteen-bit auto-reload timer.
// - Count clocks: system, system over twelve, external over eight synchronised.
// - Sixteen-bit overflow loads both reload bytes and sets high overflow flag.
// - Sixteen-bit mode: timer interrupt enable requests interrupt on every overflow.
// - Sixteen-bit mode: low-overflow enable also requests on each low byte wrap.
// - Split set, capture clear: two separate eight-bit auto-reload timers.
// - Split mode: each byte reloads from its own reload byte.
// - Split mode: run control gates only high byte; low byte counts whenever capture is clear.
// - Fast select picks system clock, else external select picks ext/8 or sys/12.
// - Split mode: each byte wrap sets its own overflow flag.
// - Split mode: timer interrupt enable requests on each high byte overflow.
// - Split mode with low enable: interrupt on either byte overflow.
// - Overflow flags stay set until software clears them explicitly.
// - Control layout: flags 7,6, low enable 5, split 3, run 2, ext 0.
module auto_reload_timer_split (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ext_clk,
   input wire timer_pkg::addr_t awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output timer_pkg::axi_resp_t bresp,
   output logic bvalid,
   input wire logic bready,
   input wire timer_pkg::addr_t araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output timer_pkg::axi_resp_t rresp,
   output logic rvalid,
   input wire logic rready,
   output logic irq
);
   import timer_pkg::*;

   function automatic logic addr_known(input addr_t a);
      if (a == `CTRL_OFS) addr_known = 1'b1;
      else if (a == `RELOAD_LOW_OFS) addr_known = 1'b1;
      else if (a == `RELOAD_HIGH_OFS) addr_known = 1'b1;
      else if (a == `LOW_COUNT_OFS) addr_known = 1'b1;
      else if (a == `HIGH_COUNT_OFS) addr_known = 1'b1;
      else if (a == `CLKCTL_OFS) addr_known = 1'b1;
      else if (a == `EXT_IE_OFS) addr_known = 1'b1;
      else if (a == `IRQ_STATUS_OFS) addr_known = 1'b1;
      else if (a == `IRQ_MASK_OFS) addr_known = 1'b1;
      else addr_known = 1'b0;
   endfunction : addr_known

   tick_if tk ();

   addr_t aw_addr_q;
   byte_t wdata_q;
   logic wstrb_q;
   logic aw_full;
   logic w_full;
   logic wr_en;
   logic rd_take;
   byte_t rd_value;

   byte_t low_count_byte;
   byte_t high_count_byte;
   byte_t reload_low_byte;
   byte_t reload_high_byte;
   logic high_overflow_flag;
   logic low_overflow_flag;
   logic low_overflow_irq_enable;
   logic split_select;
   logic run_control;
   logic external_clock_select;
   logic low_half_fast_clock_select;
   logic high_half_fast_clock_select;
   logic capture_enable;
   logic timer_irq_enable;
   logic [1:0] irq_status;
   logic [1:0] irq_mask;

   byte_t next_low;
   byte_t next_high;
   logic low_ovf;
   logic high_ovf;
   logic wr_ctrl;
   logic wr_low;
   logic wr_high;
   logic rd_status;

   count_tick_gen count_tick_gen_inst (
      .aclk(aclk),
      .aresetn(aresetn),
      .ext_clk(ext_clk),
      .tk(tk)
   );

   assign tk.fast = {high_half_fast_clock_select, low_half_fast_clock_select};
   assign tk.ext_sel = external_clock_select;

   ////////////////////////////////////////////////////////////////////////////
   // Write channel: address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b0;
         aw_full <= 1'b0;
         aw_addr_q <= `BYTE_ZERO;
      end else if (awvalid && awready) begin
         awready <= 1'b0;
         aw_full <= 1'b1;
         aw_addr_q <= awaddr;
      end else if (bvalid && bready) begin
         awready <= 1'b1;
         aw_full <= 1'b0;
      end else if (!aw_full) begin
         awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready <= 1'b0;
         w_full <= 1'b0;
         wdata_q <= `BYTE_ZERO;
         wstrb_q <= 1'b0;
      end else if (wvalid && wready) begin
         wready <= 1'b0;
         w_full <= 1'b1;
         wdata_q <= wdata[7:0];
         wstrb_q <= wstrb[0];
      end else if (bvalid && bready) begin
         wready <= 1'b1;
         w_full <= 1'b0;
      end else if (!w_full) begin
         wready <= 1'b1;
      end
   end

   assign wr_en = aw_full && w_full && !bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= resp_okay;
      end else if (wr_en) begin
         bvalid <= 1'b1;
         bresp <= addr_known(aw_addr_q) ? resp_okay : resp_slverr;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // Registers live in byte lane zero only
   assign wr_ctrl = wr_en && wstrb_q && (aw_addr_q == `CTRL_OFS);
   assign wr_low = wr_en && wstrb_q && (aw_addr_q == `LOW_COUNT_OFS);
   assign wr_high = wr_en && wstrb_q && (aw_addr_q == `HIGH_COUNT_OFS);

   ////////////////////////////////////////////////////////////////////////////
   // Read channel
   assign rd_take = arvalid && arready;
   assign rd_status = rd_take && (araddr == `IRQ_STATUS_OFS);

   always_comb begin
      rd_value = `BYTE_ZERO;
      if (araddr == `CTRL_OFS) begin
         rd_value[`HOF_BIT] = high_overflow_flag;
         rd_value[`LOF_BIT] = low_overflow_flag;
         rd_value[`LOF_IE_BIT] = low_overflow_irq_enable;
         rd_value[`SPLIT_BIT] = split_select;
         rd_value[`RUN_BIT] = run_control;
         rd_value[`XCLK_BIT] = external_clock_select;
      end else if (araddr == `RELOAD_LOW_OFS) begin
         rd_value = reload_low_byte;
      end else if (araddr == `RELOAD_HIGH_OFS) begin
         rd_value = reload_high_byte;
      end else if (araddr == `LOW_COUNT_OFS) begin
         rd_value = low_count_byte;
      end else if (araddr == `HIGH_COUNT_OFS) begin
         rd_value = high_count_byte;
      end else if (araddr == `CLKCTL_OFS) begin
         rd_value[`FAST_LOW_BIT] = low_half_fast_clock_select;
         rd_value[`FAST_HIGH_BIT] = high_half_fast_clock_select;
         rd_value[`CAPTURE_BIT] = capture_enable;
      end else if (araddr == `EXT_IE_OFS) begin
         rd_value[`TIMER_IE_BIT] = timer_irq_enable;
      end else if (araddr == `IRQ_STATUS_OFS) begin
         rd_value[1:0] = irq_status;
      end else if (araddr == `IRQ_MASK_OFS) begin
         rd_value[1:0] = irq_mask;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= resp_okay;
      end else if (rd_take) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= {24'h00_0000, rd_value};
         rresp <= addr_known(araddr) ? resp_okay : resp_slverr;
      end else if (rvalid && rready) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
      end else if (!rvalid) begin
         arready <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         reload_low_byte <= `BYTE_ZERO;
         reload_high_byte <= `BYTE_ZERO;
         low_overflow_irq_enable <= 1'b0;
         split_select <= 1'b0;
         run_control <= 1'b0;
         external_clock_select <= 1'b0;
         low_half_fast_clock_select <= 1'b0;
         high_half_fast_clock_select <= 1'b0;
         capture_enable <= 1'b0;
         timer_irq_enable <= 1'b0;
         irq_mask <= `STAT_ZERO;
      end else if (wr_en && wstrb_q) begin
         if (aw_addr_q == `CTRL_OFS) begin
            low_overflow_irq_enable <= wdata_q[`LOF_IE_BIT];
            split_select <= wdata_q[`SPLIT_BIT];
            run_control <= wdata_q[`RUN_BIT];
            external_clock_select <= wdata_q[`XCLK_BIT];
         end else if (aw_addr_q == `RELOAD_LOW_OFS) begin
            reload_low_byte <= wdata_q;
         end else if (aw_addr_q == `RELOAD_HIGH_OFS) begin
            reload_high_byte <= wdata_q;
         end else if (aw_addr_q == `CLKCTL_OFS) begin
            low_half_fast_clock_select <= wdata_q[`FAST_LOW_BIT];
            high_half_fast_clock_select <= wdata_q[`FAST_HIGH_BIT];
            capture_enable <= wdata_q[`CAPTURE_BIT];
         end else if (aw_addr_q == `EXT_IE_OFS) begin
            timer_irq_enable <= wdata_q[`TIMER_IE_BIT];
         end else if (aw_addr_q == `IRQ_MASK_OFS) begin
            irq_mask <= wdata_q[1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Counter next state
   always_comb begin
      next_low = low_count_byte;
      next_high = high_count_byte;
      low_ovf = 1'b0;
      high_ovf = 1'b0;
      if (!split_select) begin
         if (run_control && tk.tick[0]) begin
            if (low_count_byte == `BYTE_MAX) begin
               low_ovf = 1'b1;
            end
            if ({high_count_byte, low_count_byte} == `WORD_MAX) begin
               next_low = reload_low_byte;
               next_high = reload_high_byte;
               high_ovf = 1'b1;
            end else begin
               {next_high, next_low} = {high_count_byte, low_count_byte} + `WORD_ONE;
            end
         end
      end else if (!capture_enable) begin
         if (tk.tick[0]) begin
            if (low_count_byte == `BYTE_MAX) begin
               next_low = reload_low_byte;
               low_ovf = 1'b1;
            end else begin
               next_low = low_count_byte + `BYTE_ONE;
            end
         end
         if (run_control && tk.tick[1]) begin
            if (high_count_byte == `BYTE_MAX) begin
               next_high = reload_high_byte;
               high_ovf = 1'b1;
            end else begin
               next_high = high_count_byte + `BYTE_ONE;
            end
         end
      end
      if (wr_low) begin
         next_low = wdata_q;
      end
      if (wr_high) begin
         next_high = wdata_q;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         low_count_byte <= `BYTE_ZERO;
         high_count_byte <= `BYTE_ZERO;
      end else begin
         low_count_byte <= next_low;
         high_count_byte <= next_high;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sticky flags, set beats clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         high_overflow_flag <= 1'b0;
         low_overflow_flag <= 1'b0;
      end else begin
         high_overflow_flag <= (wr_ctrl ? wdata_q[`HOF_BIT] : high_overflow_flag) | high_ovf;
         low_overflow_flag <= (wr_ctrl ? wdata_q[`LOF_BIT] : low_overflow_flag) | low_ovf;
      end
   end

   // Read of status clears it, but a same-cycle event survives
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status <= `STAT_ZERO;
      end else begin
         irq_status <= (rd_status ? `STAT_ZERO : irq_status) | {low_ovf, high_ovf};
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= timer_irq_enable &&
            |(irq_status & irq_mask & {low_overflow_irq_enable, 1'b1});
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   wide_reload_a: assert property (!split_select && run_control && tk.tick[0] &&
      {high_count_byte, low_count_byte} == `WORD_MAX && !wr_low && !wr_high |=>
      {high_count_byte, low_count_byte} == {$past(reload_high_byte), $past(reload_low_byte)}
      && high_overflow_flag) else $error("wide reload missed");
   low_reload_a: assert property (split_select && !capture_enable && tk.tick[0] &&
      low_count_byte == `BYTE_MAX && !wr_low |=> low_count_byte == $past(reload_low_byte)
      && low_overflow_flag) else $error("low byte reload missed");
   high_reload_a: assert property (split_select && !capture_enable && run_control &&
      tk.tick[1] && high_count_byte == `BYTE_MAX && !wr_high |=>
      high_count_byte == $past(reload_high_byte)) else $error("high byte reload missed");
   high_gate_a: assert property (split_select && !run_control && !wr_high |=>
      $stable(high_count_byte)) else $error("high byte ran while stopped");
   low_free_a: assert property (split_select && !capture_enable && !run_control &&
      tk.tick[0] && low_count_byte != `BYTE_MAX && !wr_low |=>
      low_count_byte == $past(low_count_byte) + `BYTE_ONE) else $error("low byte stalled");
   wide_gate_a: assert property (!split_select && !run_control && !wr_low && !wr_high |=>
      $stable({high_count_byte, low_count_byte})) else $error("wide counter ran");
   flag_sticky_a: assert property (high_overflow_flag && !wr_ctrl |=> high_overflow_flag)
      else $error("high flag dropped by hardware");
   count_write_a: assert property (wr_low |=> low_count_byte == $past(wdata_q))
      else $error("low byte write lost");
   high_irq_a: assert property (high_ovf && timer_irq_enable && irq_mask[0] &&
      $stable(timer_irq_enable) [*1] |-> ##2 irq || !timer_irq_enable)
      else $error("overflow interrupt missing");
   low_irq_a: assert property (irq && !$past(irq_status[0]) |->
      $past(low_overflow_irq_enable)) else $error("low interrupt without enable");
   irq_enable_a: assert property (irq |-> $past(timer_irq_enable))
      else $error("interrupt without timer enable");

   wide_ovf_c: cover property (!split_select && high_ovf);
   split_both_c: cover property (split_select && low_ovf ##[1:600] high_ovf);
   irq_c: cover property (irq && low_overflow_irq_enable);
   read_clear_c: cover property (rd_status && (low_ovf || high_ovf));

endmodule : auto_reload_timer_split

// >>> design/count_tick_gen.sv
// Prescalers and external clock synchroniser producing per-half count ticks
`timescale 1ns/10ps
module count_tick_gen (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ext_clk,
   tick_if.gen tk
);
   import timer_pkg::*;

   logic [2:0] ext_sync;
   logic ext_level;
   logic ext_rise;
   logic [2:0] ext_div;
   logic ext_tick;
   logic [3:0] sys_div;
   logic sys_tick;

   ////////////////////////////////////////////////////////////////////////////
   // external clock synchronised
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_sync <= 3'h0;
      end else begin
         ext_sync <= {ext_sync[1:0], ext_clk};
      end
   end

   // Level only moves once second and third stages agree
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_level <= 1'b0;
      end else if (ext_sync[1] == ext_sync[2]) begin
         ext_level <= ext_sync[2];
      end
   end

   assign ext_rise = (ext_sync[1] == ext_sync[2]) && ext_sync[2] && !ext_level;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_div <= `EXT_DIV_ZERO;
      end else if (ext_rise) begin
         ext_div <= (ext_div == `EXT_DIV_LAST) ? `EXT_DIV_ZERO : ext_div + `EXT_DIV_ONE;
      end
   end

   assign ext_tick = ext_rise && (ext_div == `EXT_DIV_LAST);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sys_div <= `SYS_DIV_ZERO;
      end else begin
         sys_div <= (sys_div == `SYS_DIV_LAST) ? `SYS_DIV_ZERO : sys_div + `SYS_DIV_ONE;
      end
   end

   assign sys_tick = (sys_div == `SYS_DIV_LAST);

   ////////////////////////////////////////////////////////////////////////////
   // per-half source select
   for (genvar i = 0; i < 2; i++) begin : g_half
      assign tk.tick[i] = tk.fast[i] ? 1'b1 : (tk.ext_sel ? ext_tick : sys_tick);
   end

   sys_spacing_a: assert property (@(posedge aclk) disable iff (!aresetn)
      sys_tick |=> !sys_tick [*8]) else $error("divide by twelve tick too early");

endmodule : count_tick_gen

// >>> design/tick_if.sv
// Count clock selection and tick strobes between timer core and tick generator
`timescale 1ns/10ps
interface tick_if;
   // Index 0 is the low half, index 1 the high half
   logic [1:0] fast;
   logic ext_sel;
   logic [1:0] tick;
   modport gen (input fast, input ext_sel, output tick);
   modport user (output fast, output ext_sel, input tick);
endinterface : tick_if

// >>> design/timer_pkg.sv
// Types shared by the timer modules
package timer_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [7:0] addr_t;
   typedef enum logic [1:0] {
      resp_okay = 2'b00,
      resp_slverr = 2'b10
   } axi_resp_t;
endpackage : timer_pkg

// >>> design/timer_regs.svh
// Register offsets, field positions, reset values and divider counts of the timer
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

`define CTRL_OFS 8'h00
`define RELOAD_LOW_OFS 8'h04
`define RELOAD_HIGH_OFS 8'h08
`define LOW_COUNT_OFS 8'h0c
`define HIGH_COUNT_OFS 8'h10
`define CLKCTL_OFS 8'h14
`define EXT_IE_OFS 8'h18
`define IRQ_STATUS_OFS 8'h1c
`define IRQ_MASK_OFS 8'h20

`define HOF_BIT 7
`define LOF_BIT 6
`define LOF_IE_BIT 5
`define SPLIT_BIT 3
`define RUN_BIT 2
`define XCLK_BIT 0

`define FAST_LOW_BIT 0
`define FAST_HIGH_BIT 1
`define CAPTURE_BIT 4
`define TIMER_IE_BIT 7

`define STAT_HIGH_BIT 0
`define STAT_LOW_BIT 1

`define BYTE_ZERO 8'h00
`define BYTE_MAX 8'hff
`define WORD_MAX 16'hffff
`define WORD_ONE 16'h0001
`define BYTE_ONE 8'h01
`define STAT_ZERO 2'h0

`define SYS_DIV_LAST 4'hb
`define SYS_DIV_ZERO 4'h0
`define SYS_DIV_ONE 4'h1
`define EXT_DIV_LAST 3'h7
`define EXT_DIV_ZERO 3'h0
`define EXT_DIV_ONE 3'h1

`endif

// >>> verification/test_auto_reload_timer_split.sv
// Self-checking testbench for the split auto-reload timer
`timescale 1ns/10ps
`include "timer_regs.svh"
module test_auto_reload_timer_split;
   import timer_pkg::*;
   logic aclk, aresetn, ext_clk, ext_on, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, irq;
   addr_t awaddr, araddr;
   logic [31:0] wdata, rdata, rv;
   logic [3:0] wstrb;
   logic [1:0] ext_cnt;
   axi_resp_t bresp, rresp;
   int miscompares, checks_done;

   auto_reload_timer_split auto_reload_timer_split_inst (.aclk(aclk), .aresetn(aresetn),
      .ext_clk(ext_clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq));

   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end

   // External pin toggles every two cycles, holds its level when disabled
   always @(posedge aclk) begin
      if (ext_on) begin
         ext_cnt <= ext_cnt + 2'h1;
         ext_clk <= ext_cnt[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task wr(input addr_t a, input byte_t d, input axi_resp_t er = resp_okay);
      logic aw_left, w_left;
      awaddr <= a;
      wdata <= {24'h000000, d};
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      aw_left = 1'b1;
      w_left = 1'b1;
      // Only the watchdog ends a wait for the slave
      while (aw_left || w_left) begin
         @(posedge aclk);
         if (aw_left && awready) begin
            aw_left = 1'b0;
            awvalid <= 1'b0;
         end
         if (w_left && wready) begin
            w_left = 1'b0;
            wvalid <= 1'b0;
         end
      end
      bready <= 1'b1;
      do begin
         @(posedge aclk);
      end while (!bvalid);
      bready <= 1'b0;
      chk(bvalid, 1'b1, "write answered");
      chk(bresp, er, "write response");
   endtask : wr

   task rd(input addr_t a, input axi_resp_t er = resp_okay);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
      end while (!arready);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
      end while (!rvalid);
      rv = rdata;
      rready <= 1'b0;
      chk(rvalid, 1'b1, "read answered");
      chk(rresp, er, "read response");
   endtask : rd

   task rdc(input addr_t a, input logic [31:0] exp, input logic [31:0] m, input string what);
      rd(a);
      chk(rv & m, exp, what);
   endtask : rdc

   task idle(input int n);
      repeat (n) @(posedge aclk);
   endtask : idle

   ////////////////////////////////////////////////////////////////////////////
   task t_regs;
      rdc(`CTRL_OFS, 32'h0, 32'hffffffff, "control reset");
      wr(`CTRL_OFS, 8'hff);
      rdc(`CTRL_OFS, 32'hed, 32'hffffffff, "unused control bits");
      wr(`CTRL_OFS, 8'h00);
      rdc(`CTRL_OFS, 32'h0, 32'hff, "control cleared");
      wr(`RELOAD_LOW_OFS, 8'ha5);
      wr(`RELOAD_HIGH_OFS, 8'h5a);
      wr(`LOW_COUNT_OFS, 8'h3c);
      wr(`HIGH_COUNT_OFS, 8'hc3);
      rdc(`RELOAD_LOW_OFS, 32'ha5, 32'hffffffff, "reload low");
      rdc(`RELOAD_HIGH_OFS, 32'h5a, 32'hffffffff, "reload high");
      rdc(`LOW_COUNT_OFS, 32'h3c, 32'hffffffff, "low count");
      rdc(`HIGH_COUNT_OFS, 32'hc3, 32'hffffffff, "high count");
      wr(8'h24, 8'h11, resp_slverr);
      rd(8'h24, resp_slverr);
      chk(rv, 32'h0, "unmapped read data");
      $display("t_regs done");
   endtask : t_regs

   task t_sixteen;
      wr(`RELOAD_LOW_OFS, 8'h34);
      wr(`RELOAD_HIGH_OFS, 8'h12);
      wr(`LOW_COUNT_OFS, 8'hfe);
      wr(`HIGH_COUNT_OFS, 8'hff);
      wr(`CLKCTL_OFS, 8'h01);
      wr(`EXT_IE_OFS, 8'h80);
      wr(`IRQ_MASK_OFS, 8'h01);
      idle(20);
      rdc(`LOW_COUNT_OFS, 32'hfe, 32'hff, "halted without run");
      wr(`CTRL_OFS, 8'h04);
      idle(10);
      // Overflow must reload the whole word
      rdc(`HIGH_COUNT_OFS, 32'h12, 32'hff, "reloaded high byte");
      rdc(`CTRL_OFS, 32'h80, 32'h80, "high flag set");
      chk(irq, 1'b1, "irq on overflow");
      rdc(`IRQ_STATUS_OFS, 32'h1, 32'h1, "status high event");
      idle(3);
      chk(irq, 1'b0, "irq after status read");
      rdc(`CTRL_OFS, 32'h80, 32'h80, "flag stays set");
      wr(`CTRL_OFS, 8'h00);
      rdc(`CTRL_OFS, 32'h0, 32'hc0, "flags cleared");
      $display("t_sixteen done");
   endtask : t_sixteen

   task t_lowirq;
      wr(`LOW_COUNT_OFS, 8'hfe);
      wr(`HIGH_COUNT_OFS, 8'h00);
      wr(`IRQ_MASK_OFS, 8'h03);
      wr(`CTRL_OFS, 8'h24);
      idle(10);
      rdc(`CTRL_OFS, 32'h40, 32'hc0, "low wrap flag only");
      chk(irq, 1'b1, "irq on low wrap");
      wr(`CTRL_OFS, 8'h00);
      rdc(`IRQ_STATUS_OFS, 32'h2, 32'h3, "status low event");
      idle(3);
      chk(irq, 1'b0, "irq cleared");
      $display("t_lowirq done");
   endtask : t_lowirq

   task t_split;
      wr(`RELOAD_LOW_OFS, 8'hf0);
      wr(`HIGH_COUNT_OFS, 8'h55);
      wr(`LOW_COUNT_OFS, 8'hfe);
      wr(`CLKCTL_OFS, 8'h03);
      wr(`CTRL_OFS, 8'h08);
      idle(40);
      // Low half runs on its own, high half waits for run
      rdc(`HIGH_COUNT_OFS, 32'h55, 32'hff, "high held without run");
      rdc(`LOW_COUNT_OFS, 32'hf0, 32'hf0, "low reloads own byte");
      rdc(`CTRL_OFS, 32'h40, 32'hc0, "low flag only");
      chk(irq, 1'b0, "low wrap alone gives no irq");
      wr(`CTRL_OFS, 8'h28);
      idle(20);
      chk(irq, 1'b1, "irq on low wrap in split");
      wr(`CTRL_OFS, 8'h00);
      rd(`IRQ_STATUS_OFS);
      wr(`RELOAD_HIGH_OFS, 8'h77);
      wr(`HIGH_COUNT_OFS, 8'hfe);
      // Low starts next to its wrap so both flags land before the read
      wr(`LOW_COUNT_OFS, 8'hfe);
      wr(`CTRL_OFS, 8'h0c);
      idle(10);
      rd(`HIGH_COUNT_OFS);
      chk(rv >= 32'h77 && rv < 32'ha0, 1'b1, "high reloads own byte");
      rdc(`CTRL_OFS, 32'hc0, 32'hc0, "both flags");
      chk(irq, 1'b1, "irq on high overflow");
      wr(`CTRL_OFS, 8'h00);
      rd(`IRQ_STATUS_OFS);
      // Capture set in split mode freezes both halves
      wr(`CLKCTL_OFS, 8'h13);
      wr(`LOW_COUNT_OFS, 8'h21);
      wr(`CTRL_OFS, 8'h0c);
      idle(5);
      rdc(`LOW_COUNT_OFS, 32'h21, 32'hff, "capture holds low byte");
      wr(`CTRL_OFS, 8'h00);
      $display("t_split done");
   endtask : t_split

   task t_clocks;
      wr(`CLKCTL_OFS, 8'h00);
      wr(`LOW_COUNT_OFS, 8'h00);
      wr(`HIGH_COUNT_OFS, 8'h00);
      wr(`CTRL_OFS, 8'h04);
      idle(120);
      rd(`LOW_COUNT_OFS);
      chk(rv >= 32'h9 && rv <= 32'hb, 1'b1, "twelve-cycle prescale");
      wr(`CTRL_OFS, 8'h00);
      wr(`LOW_COUNT_OFS, 8'h00);
      ext_on <= 1'b1;
      wr(`CTRL_OFS, 8'h05);
      idle(320);
      rd(`LOW_COUNT_OFS);
      chk(rv >= 32'h8 && rv <= 32'hb, 1'b1, "external over eight");
      wr(`CTRL_OFS, 8'h00);
      ext_on <= 1'b0;
      // Fast select must override the stopped external source
      wr(`CLKCTL_OFS, 8'h01);
      wr(`LOW_COUNT_OFS, 8'h00);
      wr(`CTRL_OFS, 8'h05);
      idle(50);
      rd(`LOW_COUNT_OFS);
      chk(rv >= 32'h30 && rv <= 32'h3a, 1'b1, "fast select wins");
      wr(`CTRL_OFS, 8'h00);
      $display("t_clocks done");
   endtask : t_clocks

   task test_done;
      $display("Checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #100000;
      miscompares++;
      $display("Error at %0t: watchdog expired", $time);
      test_done();
   end

   initial begin
      aresetn = 1'b0;
      ext_clk = 1'b0;
      ext_on = 1'b0;
      ext_cnt = 2'h0;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'h0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      miscompares = 0;
      checks_done = 0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs();
      t_sixteen();
      t_lowirq();
      t_split();
      t_clocks();
      test_done();
   end
endmodule : test_auto_reload_timer_split
